// ---- core/ic_pkg.sv ----
/*
  package of the interrupt controller: register indices, field positions,
  reset values and the packed structs that join it to the core sequencer.
  assumes a 12-bit apb byte address with one register per aligned word.
*/
`default_nettype none
package ic_pkg;
  // ---------------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------------
  localparam logic [9:0] IDX_CONTROL = 10'h00B;
  localparam logic [9:0] IDX_PFLAGS = 10'h00C;
  localparam logic [9:0] IDX_OPTION = 10'h081;
  localparam logic [9:0] IDX_PENABLES = 10'h08C;
  localparam logic [9:0] IDX_POWER = 10'h08E;
  localparam logic [9:0] IDX_ANSEL_LO = 10'h091;
  localparam logic [9:0] IDX_ANSEL_HI = 10'h093;
  localparam logic [9:0] IDX_PIN_SEL = 10'h096;
  localparam logic [9:0] IDX_CORE_STAT = 10'h0A0;
  // ---------------------------------------------------------------------
  // irq_control_reg bit positions, other field positions and sizes
  // ---------------------------------------------------------------------
  localparam int B_GLB_EN = 7;
  localparam int B_PEIE = 6;
  localparam int B_TMR_EN = 5;
  localparam int B_EXTIE = 4;
  localparam int B_PCIE = 3;
  localparam int B_TMR_FLAG = 2;
  localparam int B_EXTIF = 1;
  localparam int B_PCIF = 0;
  localparam int B_EDGE = 6;      // ext_edge_polarity in option register
  localparam int B_BOR = 0;       // brown-out bit of power_control_reg
  localparam int EXT_AN_BIT = 2;  // analog select bit of the ext pin
  localparam int PORT_W = 6;
  localparam int NUM_SRC = 11;
  // ---------------------------------------------------------------------
  // reset values and vector
  // ---------------------------------------------------------------------
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_OPTION = 8'hFF;
  localparam logic [7:0] RST_ANSEL_LO = 8'hFF;
  localparam logic [3:0] RST_ANSEL_HI = 4'hF;
  localparam logic [5:0] RST_PIN_SEL = 6'h00;
  localparam logic [2:0] RST_POWER = 3'h4;
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;
  // ---------------------------------------------------------------------
  // core sequencer link
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic instr_boundary;  // pulse: an instruction finishes this cycle
    logic return_from_irq_instr; // pulse: return instruction executes
    logic sleeping;        // level: core is in sleep
  } ic_core_in_t;
  typedef struct packed {
    logic irq_pending;     // level: enabled request to the core
    logic wake;            // level: wake the core from sleep
    logic vector_load;     // pulse: load pc with vector_addr
    logic stack_push;      // pulse: push return address
    logic [12:0] vector_addr;
  } ic_core_out_t;
endpackage
`default_nettype wire

// ---- core/ic_sync.sv ----
/*
  two flip-flop synchroniser for a bus of asynchronous pin levels.
  assumes each bit is an independent level; no bus coherence.
*/
`timescale 1ns/1ps
`default_nettype none
module ic_sync #(
  parameter int W = 1
) (
  input wire logic pclk,           // clock
  input wire logic presetn,        // async reset, active low
  input wire logic [W-1:0] d,      // asynchronous input
  output logic [W-1:0] q           // synchronised level
);
  logic [W-1:0] meta_r;
  // ---------------------------------------------------------------------
  // two stages; only the second is read outside
  // ---------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ---- core/ic_top.sv ----
/*
  interrupt controller of a small 8-bit microcontroller: flag and enable
  registers over apb, pin edge and port change capture, vectoring to the
  core sequencer, wake from sleep.
  requests follow next-state flags, so a flag and its request rise on one
  edge and a clearing write drops both together.
  assumes timer and peripheral events are one-cycle pulses on pclk and
  pins are asynchronous; por_n is the power-on reset only.
*/
`timescale 1ns/1ps
`default_nettype none
module ic_top (
  input wire logic pclk,                       // instruction-cycle clock
  input wire logic presetn,                    // async reset, active low
  input wire logic por_n,                      // power-on reset, active low
  input wire logic bor_cause,                  // reset was a brown-out
  input wire logic psel,                       // apb select
  input wire logic penable,                    // apb enable
  input wire logic pwrite,                     // apb direction
  input wire logic [11:0] paddr,               // apb byte address
  input wire logic [31:0] pwdata,              // apb write data
  output logic [31:0] prdata,                  // apb read data
  output logic pready,                         // apb ready
  output logic pslverr,                        // apb error, unmapped
  input wire logic ext_irq_pin,                // external irq pin
  input wire logic [ic_pkg::PORT_W-1:0] port_in, // general port pins
  input wire logic timer0_wrap,                // timer0_count ff->00
  input wire logic [7:0] periph_evt,           // peripheral event pulses
  input wire ic_pkg::ic_core_in_t core_in,     // from core sequencer
  output ic_pkg::ic_core_out_t core_out        // to core sequencer
);
  import ic_pkg::*;

  logic [7:0] irq_control_reg_r;
  logic [7:0] periph_irq_flags_r;
  logic [7:0] periph_irq_enables_r;
  logic [7:0] option_r;
  logic [7:0] analog_select_low_r;
  logic [3:0] analog_select_high_r;
  logic [5:0] per_pin_change_select_r;
  logic [2:0] power_control_reg_r;
  logic bor_check_r;
  logic ext_sync;
  logic [PORT_W-1:0] port_sync;
  logic ext_dig;
  logic ext_prev_r;
  logic [PORT_W-1:0] port_dig;
  logic [PORT_W-1:0] port_prev_r;
  logic ext_edge;
  logic port_change;
  logic [9:0] idx;
  logic wr_en;
  logic ctrl_wr;
  logic pflag_wr;
  logic take_irq;
  logic [7:0] ctrl_nxt;
  logic [7:0] pflag_nxt;
  logic main_hit;
  logic periph_hit;
  logic any_hit;
  logic [31:0] rd_nxt;
  logic map_ok;

  // ---------------------------------------------------------------------
  // pin capture
  // ---------------------------------------------------------------------
  // every pin passes two flip-flops before any logic reads it
  ic_sync #(.W(1)) u_sync_ext (
    .pclk(pclk),
    .presetn(presetn),
    .d(ext_irq_pin),
    .q(ext_sync)
  );
  // port pins share one bank; each bit is synchronised on its own
  ic_sync #(.W(PORT_W)) u_sync_port (
    .pclk(pclk),
    .presetn(presetn),
    .d(port_in),
    .q(port_sync)
  );

  // analog-selected pins read as zero on the digital path
  assign ext_dig = ext_sync & ~analog_select_low_r[EXT_AN_BIT];
  assign port_dig = port_sync & ~analog_select_low_r[PORT_W-1:0];

  // previous digital levels for edge and change detection
  // reset low matches the masked level of analog-selected pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_prev_r <= 1'b0;
      port_prev_r <= '0;
    end else begin
      ext_prev_r <= ext_dig;
      port_prev_r <= port_dig;
    end
  end

  // edge of chosen polarity and change on selected pins
  // a pin whose select bit is clear never raises the change flag
  assign ext_edge = option_r[B_EDGE] ? (ext_dig & ~ext_prev_r)
                                     : (~ext_dig & ext_prev_r);
  assign port_change =
    |((port_dig ^ port_prev_r) & per_pin_change_select_r);

  // ---------------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------------
  // a write lands at the access edge, where ready is sampled high;
  // there is one access cycle and no further wait state
  assign idx = paddr[11:2];
  assign wr_en = psel & penable & pready & pwrite;
  assign ctrl_wr = wr_en & (idx == IDX_CONTROL);
  assign pflag_wr = wr_en & (idx == IDX_PFLAGS);

  // ---------------------------------------------------------------------
  // request and vectoring decision
  // ---------------------------------------------------------------------
  // request terms read next-state flags and next-state irq_control_reg enables: the request rises on
  // the edge that sets the flag, three edges after a pin change, and a
  // clearing write drops it on the edge at which it lands
  assign main_hit =
    (ctrl_nxt[B_TMR_FLAG] & ctrl_nxt[B_TMR_EN]) |
    (ctrl_nxt[B_EXTIF] & ctrl_nxt[B_EXTIE]) |
    (ctrl_nxt[B_PCIF] & ctrl_nxt[B_PCIE]);
  // peripheral requests also need the peripheral group enable
  assign periph_hit = ctrl_nxt[B_PEIE] &
    (|(pflag_nxt & periph_irq_enables_r));
  assign any_hit = main_hit | periph_hit;
  // vector only at an instruction boundary while awake; after a wake the
  // next instruction's boundary comes first, and a sleeping core never
  // takes: wake is raised instead
  assign take_irq = core_out.irq_pending & core_in.instr_boundary &
                    ~core_in.sleeping;

  // ---------------------------------------------------------------------
  // control register: flags, enables, global enable
  // ---------------------------------------------------------------------
  always_comb begin
    ctrl_nxt = ctrl_wr ? pwdata[7:0] : irq_control_reg_r;
    // a return beats a bus write; a take beats both
    if (core_in.return_from_irq_instr) begin
      ctrl_nxt[B_GLB_EN] = 1'b1;
    end
    if (take_irq) begin
      ctrl_nxt[B_GLB_EN] = 1'b0;
    end
    // events win over a clearing write; enables are not consulted
    ctrl_nxt[B_TMR_FLAG] = ctrl_nxt[B_TMR_FLAG] | timer0_wrap;
    ctrl_nxt[B_EXTIF] = ctrl_nxt[B_EXTIF] | ext_edge;
    ctrl_nxt[B_PCIF] = ctrl_nxt[B_PCIF] | port_change;
  end

  // peripheral flags with set winning over clear
  assign pflag_nxt = (pflag_wr ? pwdata[7:0] : periph_irq_flags_r) |
                     periph_evt;

  // control register state; reset clears the global enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_control_reg_r <= RST_ZERO;
    end else begin
      irq_control_reg_r <= ctrl_nxt;
    end
  end

  // peripheral flag and enable registers
  // enables have no events; only a write changes them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_irq_flags_r <= RST_ZERO;
      periph_irq_enables_r <= RST_ZERO;
    end else begin
      periph_irq_flags_r <= pflag_nxt;
      if (wr_en && idx == IDX_PENABLES) begin
        periph_irq_enables_r <= pwdata[7:0];
      end
    end
  end

  // configuration registers for pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      option_r <= RST_OPTION;
      analog_select_low_r <= RST_ANSEL_LO;
      analog_select_high_r <= RST_ANSEL_HI;
      per_pin_change_select_r <= RST_PIN_SEL;
    end else if (wr_en) begin
      case (idx)
        IDX_OPTION: option_r <= pwdata[7:0];
        IDX_ANSEL_LO: analog_select_low_r <= pwdata[7:0];
        // the high analog bank has no pin here; kept for software
        IDX_ANSEL_HI: analog_select_high_r <= pwdata[3:0];
        IDX_PIN_SEL: per_pin_change_select_r <= pwdata[5:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // power control: kept across ordinary resets
  // ---------------------------------------------------------------------
  // first cycle after presetn release looks at the reset cause
  // it is set all through reset, so a cause held over reset is seen too
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bor_check_r <= 1'b1;
    end else begin
      bor_check_r <= 1'b0;
    end
  end

  // only power-on resets it; a brown-out clears bit 0 during reset or the first cycle after release
  // bits 2:1 are plain software bits; the cause input matters only while
  // bor_check_r is high
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      power_control_reg_r <= RST_POWER;
    end else if (bor_check_r && bor_cause) begin
      power_control_reg_r[B_BOR] <= 1'b0;
    end else if (wr_en && idx == IDX_POWER) begin
      power_control_reg_r <= pwdata[2:0];
    end
  end

  // ---------------------------------------------------------------------
  // core link
  // ---------------------------------------------------------------------
  // pending request, wake and vector pulses; a cleared global enable holds
  // requests off but leaves their flags pending; vector_load and stack_push
  // are one-cycle pulses on the edge after a take
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_out.irq_pending <= 1'b0;
      core_out.wake <= 1'b0;
      core_out.vector_load <= 1'b0;
      core_out.stack_push <= 1'b0;
      core_out.vector_addr <= IRQ_VECTOR;
    end else begin
      core_out.irq_pending <= ctrl_nxt[B_GLB_EN] & any_hit;
      core_out.wake <= core_in.sleeping & any_hit;
      core_out.vector_load <= take_irq;
      core_out.stack_push <= take_irq;
      core_out.vector_addr <= IRQ_VECTOR;
    end
  end

  // ---------------------------------------------------------------------
  // apb read and answer
  // ---------------------------------------------------------------------
  // read data follows the index as it stands in the setup cycle
  always_comb begin
    rd_nxt = '0;
    map_ok = 1'b1;
    case (idx)
      IDX_CONTROL: rd_nxt[7:0] = irq_control_reg_r;
      IDX_PFLAGS: rd_nxt[7:0] = periph_irq_flags_r;
      IDX_PENABLES: rd_nxt[7:0] = periph_irq_enables_r;
      IDX_OPTION: rd_nxt[7:0] = option_r;
      IDX_POWER: rd_nxt[2:0] = power_control_reg_r;
      IDX_ANSEL_LO: rd_nxt[7:0] = analog_select_low_r;
      IDX_ANSEL_HI: rd_nxt[3:0] = analog_select_high_r;
      IDX_PIN_SEL: rd_nxt[5:0] = per_pin_change_select_r;
      IDX_CORE_STAT: rd_nxt[2:0] = {core_out.wake, core_out.irq_pending,
                                    ext_dig};
      default: map_ok = 1'b0;
    endcase
  end

  // ready one cycle after setup; data and error captured with it
  // an unmapped index raises pslverr with ready; its write is ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable & ~pready;
      prdata <= (psel & ~penable & ~pwrite) ? rd_nxt : '0;
      pslverr <= psel & ~penable & ~map_ok;
    end
  end
endmodule
`default_nettype wire

// ---- verif/ic_core_model.sv ----
/*
  core sequencer model: gives instruction boundaries, return pulses and
  sleep, and counts vectors taken. assumes the controller's core link.
*/
`timescale 1ns/1ps
`default_nettype none
module ic_core_model (
  input wire logic pclk,                    // clock
  input wire logic presetn,                 // reset, active low
  input wire ic_pkg::ic_core_out_t core_out, // from controller
  input wire logic sleep_req,               // hold the core asleep
  input wire logic ret_req,                 // run one return
  input wire logic slow,                    // two-cycle instructions
  output ic_pkg::ic_core_in_t core_in,      // to controller
  output int vec_count                      // vectors taken
);
  import ic_pkg::*;
  logic [1:0] busy_r;
  logic phase_r;
  // -------------------------------------------------------------------
  // sequencer
  // -------------------------------------------------------------------
  // no boundary while asleep, or for a while after a take
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_in <= '0;
      busy_r <= 2'h0;
      phase_r <= 1'b0;
      vec_count <= 0;
    end else begin
      phase_r <= slow ? ~phase_r : 1'b1;
      busy_r <= core_out.vector_load ? 2'h2 :
        (busy_r == 2'h0 ? 2'h0 : busy_r - 2'h1);
      core_in.instr_boundary <= !sleep_req && phase_r && busy_r == 2'h0 &&
        !core_out.vector_load &&
        !(core_in.instr_boundary && core_out.irq_pending);
      core_in.return_from_irq_instr <= ret_req;
      core_in.sleeping <= sleep_req;
      if (core_out.vector_load && core_out.stack_push) begin
        vec_count <= vec_count + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- verif/ic_top_properties.sv ----
/*
  port assertions of the interrupt controller.
  assumes binding to ic_top; one clock, reset active low.
*/
`timescale 1ns/1ps
`default_nettype none
module ic_top_properties (
  input wire logic pclk,                    // clock
  input wire logic presetn,                 // reset, active low
  input wire logic psel,                    // apb select
  input wire logic penable,                 // apb enable
  input wire logic [31:0] prdata,           // apb read data
  input wire logic pready,                  // apb ready
  input wire logic pslverr,                 // apb error
  input wire ic_pkg::ic_core_in_t core_in,  // from core
  input wire ic_pkg::ic_core_out_t core_out // to core
);
  import ic_pkg::*;
  // -------------------------------------------------------------------
  // vectoring and bus relations
  // -------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_take;
    core_out.irq_pending && core_in.instr_boundary && !core_in.sleeping;
  endsequence
  sequence s_vector;
    core_out.vector_load && core_out.stack_push ##1 !core_out.vector_load;
  endsequence
  a_take_vectors: assert property (s_take |=> s_vector)
    else $error("no vector after a take");
  a_load_cause: assert property (core_out.vector_load |->
    $past(core_out.irq_pending) && !$past(core_in.sleeping))
    else $error("vector without request");
  a_gie_cleared: assert property (core_out.vector_load &&
    !core_in.return_from_irq_instr |=> !core_out.irq_pending)
    else $error("request stays after vector");
  a_vector_fixed: assert property (core_out.vector_addr == IRQ_VECTOR)
    else $error("wrong vector address");
  a_sleep_holds: assert property (core_in.sleeping [*2]
    |-> !core_out.vector_load)
    else $error("vector while asleep");
  a_wake_asleep: assert property (core_out.wake |->
    $past(core_in.sleeping))
    else $error("wake while awake");
  a_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("bad ready timing");
  a_err_ready: assert property (pslverr || !pready |-> pready ||
    prdata == 32'h0 && !pslverr)
    else $error("read data or error outside ready");
endmodule
bind ic_top ic_top_properties ic_top_properties_i (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .core_in(core_in),
  .core_out(core_out));
`default_nettype wire

// ---- verif/ic_top_tb.sv ----
/*
  self-checking bench of the interrupt controller.
  assumes ic_pkg, ic_top, ic_core_model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module ic_top_tb;
  import ic_pkg::*;
  logic pclk, presetn, por_n, bor_cause, psel, penable, pwrite, pready;
  logic pslverr, rerr, ext_irq_pin, timer0_wrap, sleep_req, ret_req;
  logic slow;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [PORT_W-1:0] port_in;
  logic [7:0] periph_evt, pen;
  ic_core_in_t core_in;
  ic_core_out_t core_out;
  int vec_count, num_errors, check_count, n, i, p, v0;
  integer seed;
  logic [9:0] idx_t [8] = '{IDX_CONTROL, IDX_PFLAGS, IDX_PENABLES,
    IDX_OPTION, IDX_ANSEL_LO, IDX_ANSEL_HI, IDX_PIN_SEL, IDX_POWER};
  logic [31:0] rst_t [8] = '{32'h0, 32'h0, 32'h0, 32'hFF, 32'hFF, 32'hF,
    32'h0, 32'h4};
  ic_top ic_top_i (.pclk(pclk), .presetn(presetn), .por_n(por_n),
    .bor_cause(bor_cause), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_irq_pin(ext_irq_pin),
    .port_in(port_in), .timer0_wrap(timer0_wrap),
    .periph_evt(periph_evt), .core_in(core_in), .core_out(core_out));
  ic_core_model ic_core_model_i (.pclk(pclk), .presetn(presetn),
    .core_out(core_out), .sleep_req(sleep_req), .ret_req(ret_req),
    .slow(slow), .core_in(core_in), .vec_count(vec_count));
  // -------------------------------------------------------------------
  // clock, helpers
  // -------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic report_and_stop();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_up();
    num_errors++;
    $display("mismatch at %0t: wait ran out", $time);
    report_and_stop();
  endtask
  function automatic logic exp_wake(input logic [7:0] en, input int b);
    return en[b];
  endfunction
  // one apb transfer, held until the ready edge
  task automatic apb(input logic [9:0] idx, input logic wr,
    input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // values read just after an edge are those sampled at it
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) give_up();
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
    apb(idx, 1'b0, 32'h0);
    check(rdata, exp);
  endtask
  task automatic pulse_t0();
    @(posedge pclk);
    timer0_wrap <= 1'b1;
    @(posedge pclk);
    timer0_wrap <= 1'b0;
  endtask
  task automatic wait_vec(input int target);
    int k;
    for (k = 0; k < 40 && vec_count != target; k++) @(negedge pclk);
    if (k == 40) give_up();
    check(vec_count, target);
  endtask
  // move the pin, then count edges until a request shows
  task automatic pin_to(input logic lvl);
    @(posedge pclk);
    ext_irq_pin <= lvl;
    for (n = -1; n < 10 && core_out.irq_pending !== 1'b1; n++)
      @(negedge pclk);
  endtask
  task automatic do_reset(input logic bor);
    @(posedge pclk);
    bor_cause <= bor;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    bor_cause <= 1'b0;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    give_up();
  end
  // -------------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------------
  initial begin
    {presetn, por_n, bor_cause, psel, penable, pwrite} = 6'h00;
    {ext_irq_pin, timer0_wrap, sleep_req, ret_req, slow} = 5'h00;
    {paddr, pwdata, port_in, periph_evt} = '0;
    {num_errors, check_count} = '0;
    seed = 32'h875fa1d7;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    for (i = 0; i < 8; i++) rd(idx_t[i], rst_t[i]);
    apb(10'h3FF, 1'b1, 32'hFF);
    check(rerr, 1'b1);
    apb(10'h3FF, 1'b0, 32'h0);
    check(rdata, 32'h0);
    check(rerr, 1'b1);
    // timer wrap, masked then taken, then return
    apb(IDX_CONTROL, 1'b1, 32'h20);
    pulse_t0();
    rd(IDX_CONTROL, 32'h24);
    check(core_out.irq_pending, 1'b0);
    apb(IDX_CONTROL, 1'b1, 32'hA4);
    wait_vec(1);
    rd(IDX_CONTROL, 32'h24);
    apb(IDX_CONTROL, 1'b1, 32'h20);
    @(posedge pclk);
    ret_req <= 1'b1;
    @(posedge pclk);
    ret_req <= 1'b0;
    rd(IDX_CONTROL, 32'hA0);
    check(vec_count, 1);
    pulse_t0();
    wait_vec(2);
    // pin on an analog-selected input, then both polarities
    apb(IDX_CONTROL, 1'b1, 32'h10);
    apb(IDX_CORE_STAT, 1'b1, 32'hFF);
    pin_to(1'b1);
    rd(IDX_CONTROL, 32'h10);
    rd(IDX_CORE_STAT, 32'h0);
    apb(IDX_ANSEL_LO, 1'b1, 32'h0);
    rd(IDX_CORE_STAT, 32'h1);
    for (p = 1; p >= 0; p--) begin
      apb(IDX_OPTION, 1'b1, p ? 32'hFF : 32'hBF);
      pin_to(p[0]);
      v0 = vec_count;
      apb(IDX_CONTROL, 1'b1, 32'h90);
      pin_to(!p[0]);
      rd(IDX_CONTROL, 32'h90);
      pin_to(p[0]);
      check(n >= 3 && n <= 4, 32'h1);
      wait_vec(v0 + 1);
      rd(IDX_CONTROL, 32'h12);
    end
    // port change on a selected and an unselected pin
    apb(IDX_PIN_SEL, 1'b1, 32'h1);
    apb(IDX_CONTROL, 1'b1, 32'h08);
    port_in <= 6'h02;
    repeat (4) @(posedge pclk);
    rd(IDX_CONTROL, 32'h08);
    port_in <= 6'h03;
    repeat (4) @(posedge pclk);
    rd(IDX_CONTROL, 32'h09);
    // peripheral events while asleep, random enables
    sleep_req <= 1'b1;
    apb(IDX_CONTROL, 1'b1, 32'h40);
    for (i = 0; i < 8; i++) begin
      pen = 8'($random(seed));
      apb(IDX_PENABLES, 1'b1, {24'h0, pen});
      @(posedge pclk);
      periph_evt <= 8'(1 << i);
      @(posedge pclk);
      periph_evt <= 8'h00;
      rd(IDX_PFLAGS, 32'h1 << i);
      check(core_out.wake, exp_wake(pen, i));
      apb(IDX_PFLAGS, 1'b1, 32'h0);
    end
    // wake with the global enable set, slow instructions
    slow <= 1'b1;
    apb(IDX_PENABLES, 1'b1, 32'h1);
    @(posedge pclk);
    periph_evt <= 8'h01;
    @(posedge pclk);
    periph_evt <= 8'h00;
    v0 = vec_count;
    apb(IDX_CONTROL, 1'b1, 32'hC0);
    check(core_out.wake, 1'b1);
    check(vec_count, v0);
    sleep_req <= 1'b0;
    wait_vec(v0 + 1);
    // brown-out and plain resets
    apb(IDX_POWER, 1'b1, 32'h7);
    do_reset(1'b1);
    rd(IDX_POWER, 32'h6);
    rd(IDX_CONTROL, 32'h0);
    do_reset(1'b0);
    rd(IDX_POWER, 32'h6);
    report_and_stop();
  end
endmodule
`default_nettype wire
